// ===== hdl/backup_cell_charger_ctrl.sv
// Charger control logic: enable bits, target voltage and current selection.
// Assumes system state comes from on-chip logic on the same clock, the
// undervoltage flag and fused default come from analog/fuse pins.
`timescale 1ns/10ps

// Function
// [RULE1] Run enable low keeps charger off in run and standby.
// [RULE2] Run enable high turns charger on in run and standby.
// [RULE3] Undervoltage crossing clears the run enable bit.
// [RULE4] Charging in run uses the 60 uA high current.
// [RULE5] Charging in standby uses the 10 uA low current.
// [RULE6] Off-state enable bit gates charging in the quick power-up off state.
// [RULE7] Charging in quick power-up off state uses the low current.
// [RULE8] Software sets off-state enable while running to charge when off.
// [RULE9] Undervoltage crossing clears the off-state enable bit.
// [RULE10] Four-bit code selects target voltage, 1.8 V to 3.6 V.
// [RULE11] Target voltage field defaults from the fused configuration field.
// [RULE12] All other system states keep the charger off.
module backup_cell_charger_ctrl (
   input wire logic clock,
   input wire logic rstn,
   // AXI4-Lite slave
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // System side
   input wire chg_pkg::sys_state_e sys_state,
   input wire logic input_undervoltage_detect,
   input wire logic [3:0] fused_charge_target_default,
   output chg_pkg::charger_cmd_s charger_cmd,
   output logic [9:0] target_mv10
);
   // ==========================================================
   // Input synchronisation
   logic uv_s;
   logic uv_prev_q;
   logic [3:0] fuse_m_q;
   logic [3:0] fuse_s_q;
   logic fuse_loaded_q;
   logic uv_cross;

   chg_sync u_uv_sync (
      .clock(clock),
      .rstn(rstn),
      .async_in(input_undervoltage_detect),
      .sync_out(uv_s)
   );

   // Fuse bits are static after power-up; a plain two-flop pass is enough.
   // No reset here on purpose: the stages keep sampling during reset, so
   // the fused code is settled when the first load after release reads it.
   always_ff @(posedge clock) begin
      fuse_m_q <= fused_charge_target_default;
      fuse_s_q <= fuse_m_q;
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         uv_prev_q <= 1'b0;
      end else begin
         uv_prev_q <= uv_s;
      end
   end

   // Either direction of crossing counts as an undervoltage event
   assign uv_cross = uv_s ^ uv_prev_q;

   // ==========================================================
   // AXI4-Lite write path
   logic aw_held_q;
   logic w_held_q;
   logic [3:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic do_write;
   logic wr_ctrl;
   logic wr_volt;
   logic run_en_q;
   logic off_en_q;
   logic [3:0] vsel_q;

   assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

   function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] reg_addr);
      addr_hit = (a == reg_addr);
   endfunction : addr_hit

   assign wr_ctrl = do_write && addr_hit(aw_addr_q, chg_pkg::ctrl_addr) && w_strb_q[0];
   assign wr_volt = do_write && addr_hit(aw_addr_q, chg_pkg::volt_addr) && w_strb_q[0];

   always_ff @(posedge clock) begin
      if (!rstn) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= 4'h0;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_q && !s_axi_awready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr[3:0];
            s_axi_awready <= 1'b0;
         end else if (do_write) begin
            aw_held_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         w_held_q <= 1'b0;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_held_q && !s_axi_wready;
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (do_write) begin
            w_held_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (addr_hit(aw_addr_q, chg_pkg::ctrl_addr) ||
                         addr_hit(aw_addr_q, chg_pkg::volt_addr) ||
                         addr_hit(aw_addr_q, chg_pkg::stat_addr)) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Enable bits: the undervoltage event beats a software write
   always_ff @(posedge clock) begin
      if (!rstn) begin
         run_en_q <= chg_pkg::ctrl_reset;
         off_en_q <= chg_pkg::ctrl_reset;
      end else if (uv_cross) begin
         run_en_q <= 1'b0; // [RULE3]
         off_en_q <= 1'b0; // [RULE9]
      end else if (wr_ctrl) begin
         run_en_q <= w_data_q[chg_pkg::run_en_bit];
         off_en_q <= w_data_q[chg_pkg::off_en_bit]; // [RULE8]
      end
   end

   // Target voltage reloads from fuses after reset and at each crossing
   always_ff @(posedge clock) begin
      if (!rstn) begin
         vsel_q <= chg_pkg::volt_reset;
         fuse_loaded_q <= 1'b0;
      end else if (!fuse_loaded_q || uv_cross) begin
         vsel_q <= fuse_s_q; // [RULE11]
         fuse_loaded_q <= 1'b1;
      end else if (wr_volt) begin
         vsel_q <= w_data_q[chg_pkg::vsel_lsb +: 4];
      end
   end

   // ==========================================================
   // Charger decision
   logic on_d;
   logic hi_d;

   always_comb begin
      on_d = 1'b0;
      hi_d = chg_pkg::isel_lo;
      case (sys_state)
         chg_pkg::st_run: begin
            on_d = run_en_q; // [RULE1] [RULE2]
            hi_d = chg_pkg::isel_hi; // [RULE4]
         end
         chg_pkg::st_standby: begin
            on_d = run_en_q; // [RULE1] [RULE2]
            hi_d = chg_pkg::isel_lo; // [RULE5]
         end
         chg_pkg::st_quick_powerup_off_state: begin
            on_d = off_en_q; // [RULE6]
            hi_d = chg_pkg::isel_lo; // [RULE7]
         end
         default: begin
            on_d = 1'b0; // [RULE12]
            hi_d = chg_pkg::isel_lo;
         end
      endcase
   end

   // Target voltage decode in tens of millivolts
   function automatic logic [9:0] code_to_mv10(input logic [3:0] code);
      if (code == 4'h0) begin
         code_to_mv10 = chg_pkg::mv10_at_zero;
      end else if (code == chg_pkg::vsel_top) begin
         code_to_mv10 = chg_pkg::mv10_at_top;
      end else begin
         code_to_mv10 = 10'(chg_pkg::mv10_at_one + chg_pkg::mv10_step * 10'(code - 4'h1));
      end
   endfunction : code_to_mv10

   always_ff @(posedge clock) begin
      if (!rstn) begin
         charger_cmd <= '0;
         target_mv10 <= chg_pkg::mv10_at_zero;
      end else begin
         charger_cmd.on <= on_d;
         charger_cmd.hi_current <= on_d && hi_d;
         charger_cmd.target <= vsel_q; // [RULE10]
         target_mv10 <= code_to_mv10(vsel_q); // [RULE10]
      end
   end

   // ==========================================================
   // AXI4-Lite read path
   logic [31:0] rd_d;
   logic rd_hit;

   always_comb begin
      rd_d = 32'h0;
      rd_hit = 1'b1;
      case (s_axi_araddr[3:0])
         chg_pkg::ctrl_addr: begin
            rd_d[chg_pkg::run_en_bit] = run_en_q;
            rd_d[chg_pkg::off_en_bit] = off_en_q;
         end
         chg_pkg::volt_addr: begin
            rd_d[chg_pkg::vsel_lsb +: 4] = vsel_q;
         end
         chg_pkg::stat_addr: begin
            rd_d[chg_pkg::stat_on_bit] = charger_cmd.on;
            rd_d[chg_pkg::stat_hi_bit] = charger_cmd.hi_current;
            rd_d[chg_pkg::stat_state_lsb +: 3] = sys_state;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b1 :
                          (!s_axi_rvalid && !s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_d;
            s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : backup_cell_charger_ctrl

// ===== hdl/chg_pkg.sv
// Shared constants and types for the backup cell charger control block.
// Assumes a 32-bit AXI4-Lite register bus and a single 25 MHz clock domain.
package chg_pkg;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [3:0] ctrl_addr = 4'h0;
   localparam logic [3:0] volt_addr = 4'h4;
   localparam logic [3:0] stat_addr = 4'h8;
   // ==========================================================
   // Field positions
   localparam int run_en_bit = 0;
   localparam int off_en_bit = 1;
   localparam int vsel_lsb = 0;
   localparam int stat_on_bit = 0;
   localparam int stat_hi_bit = 1;
   localparam int stat_state_lsb = 4;
   // ==========================================================
   // Reset values
   localparam logic ctrl_reset = 1'b0;
   localparam logic [3:0] volt_reset = 4'h0;
   // ==========================================================
   // Charge currents in microamps and their current-select coding
   localparam int hi_current_ua = 60;
   localparam int lo_current_ua = 10;
   localparam logic isel_hi = 1'b1;
   localparam logic isel_lo = 1'b0;
   // Target voltage codes in tens of millivolts
   localparam logic [3:0] vsel_top = 4'hf;
   localparam logic [9:0] mv10_at_zero = 10'h0b4;
   localparam logic [9:0] mv10_at_one = 10'h0c8;
   localparam logic [9:0] mv10_at_top = 10'h168;
   localparam logic [9:0] mv10_step = 10'h00a;
   // ==========================================================
   // Timing: cycles of undervoltage input settling
   localparam int sync_stages = 2;
   // ==========================================================
   // System state coding
   typedef enum logic [2:0] {
      st_off,
      st_run,
      st_standby,
      st_quick_powerup_off_state,
      st_other
   } sys_state_e;
   typedef struct packed {
      logic on;
      logic hi_current;
      logic [3:0] target;
   } charger_cmd_s;
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } wr_req_s;
endpackage : chg_pkg

// ===== hdl/chg_sync.sv
// Two-flop synchroniser for asynchronous level inputs.
// Assumes the input is a slow level; nothing reads the first stage but the second.
`timescale 1ns/10ps
module chg_sync (
   input wire logic clock,
   input wire logic rstn,
   input wire logic async_in,
   output logic sync_out
);
   logic meta_q;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         meta_q <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : chg_sync

// ===== tb/chg_chk.sv
// Checker for the backup cell charger control block.
// Assumes it is bound to backup_cell_charger_ctrl and sees its ports only.
`timescale 1ns/10ps
module chg_chk (
   input wire logic clock,
   input wire logic rstn,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire chg_pkg::sys_state_e sys_state,
   input wire chg_pkg::charger_cmd_s charger_cmd,
   input wire logic [9:0] target_mv10
);
   // ==========================================================
   // Properties
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   // Own decode of the target code, kept apart from the design's
   function automatic logic [9:0] mv(input logic [3:0] c);
      return c == 4'hf ? 10'h168 : c == 4'h0 ? 10'h0b4 : 10'h0be + 10'(c) * 10'h00a;
   endfunction : mv
   sequence s_settled;
      $stable(charger_cmd.target) [*3];
   endsequence
   property p_volt;
      s_settled |-> target_mv10 == mv(charger_cmd.target);
   endproperty
   property p_other;
      charger_cmd.on |-> $past(sys_state) inside {chg_pkg::st_run, chg_pkg::st_standby,
         chg_pkg::st_quick_powerup_off_state};
   endproperty
   property p_hi;
      charger_cmd.on && $past(sys_state) == chg_pkg::st_run |-> charger_cmd.hi_current;
   endproperty
   property p_lo;
      charger_cmd.on && $past(sys_state) != chg_pkg::st_run |-> !charger_cmd.hi_current;
   endproperty
   property p_hioff;
      !charger_cmd.on |-> !charger_cmd.hi_current;
   endproperty
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_bresp;
      s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2;
   endproperty
   a_volt: assert property (p_volt) else $error("target voltage mismatch");
   a_other: assert property (p_other) else $error("charger on in idle state");
   a_hi: assert property (p_hi) else $error("low current in run");
   a_lo: assert property (p_lo) else $error("high current outside run");
   a_hioff: assert property (p_hioff) else $error("high current while off");
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   a_bresp: assert property (p_bresp) else $error("bad write response");
endmodule : chg_chk
bind backup_cell_charger_ctrl chg_chk u_chk (.clock(clock), .rstn(rstn),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .sys_state(sys_state), .charger_cmd(charger_cmd), .target_mv10(target_mv10));

// ===== tb/cell_model.sv
// Backup cell seen from the charger pin: reports the current it receives.
// Assumes the command word drives the analog charger directly.
`timescale 1ns/10ps
module cell_model (
   input wire chg_pkg::charger_cmd_s cmd,
   output logic [31:0] current_ua
);
   // Idle charger sinks nothing into the cell
   always_comb current_ua = !cmd.on ? 32'h0 :
      cmd.hi_current ? 32'(chg_pkg::hi_current_ua) : 32'(chg_pkg::lo_current_ua);
endmodule : cell_model

// ===== tb/tb_top.sv
// Self-checking bench for the charger control block.
// Assumes one 25 MHz clock and an AXI4-Lite master of its own.
`timescale 1ns/10ps
module tb_top;
   typedef struct {logic [1:0] ctrl; chg_pkg::sys_state_e st; logic on; logic [31:0] ua;} row_s;
   logic clock = 1'b0, rstn = 1'b0, uv = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d, ua;
   logic [1:0] bresp, rresp, r;
   logic [3:0] fuse = 4'ha;
   logic [9:0] mv10;
   chg_pkg::sys_state_e st = chg_pkg::st_off;
   chg_pkg::charger_cmd_s cmd;
   int num_errors = 0, checks_done = 0, cyc = 0;
   row_s rows[9] = '{'{2'h0, chg_pkg::st_run, 1'b0, 32'h0}, '{2'h1, chg_pkg::st_run, 1'b1, 32'h3c},
      '{2'h1, chg_pkg::st_standby, 1'b1, 32'ha}, '{2'h0, chg_pkg::st_standby, 1'b0, 32'h0},
      '{2'h1, chg_pkg::st_quick_powerup_off_state, 1'b0, 32'h0}, '{2'h2, chg_pkg::st_run, 1'b0, 32'h0},
      '{2'h2, chg_pkg::st_quick_powerup_off_state, 1'b1, 32'ha}, '{2'h3, chg_pkg::st_other, 1'b0, 32'h0},
      '{2'h3, chg_pkg::st_off, 1'b0, 32'h0}};
   always #20 clock = ~clock;
   backup_cell_charger_ctrl dut (.clock(clock), .rstn(rstn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sys_state(st),
      .input_undervoltage_detect(uv), .fused_charge_target_default(fuse), .charger_cmd(cmd),
      .target_mv10(mv10));
   cell_model u_cell (.cmd(cmd), .current_ua(ua));
   // ==========================================================
   // Bus and check tasks
   task automatic axw(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge clock);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
   endtask : axw
   task automatic axr(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask : axr
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         num_errors++;
      end
   endtask : chk
   task automatic test_done;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done
   // Generous ceiling; the whole sequence needs well under 2000 cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         test_done();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      chk(32'(cmd.on), 32'h0);
      axr(32'h4, d, r);
      chk(d, 32'(fuse));
      foreach (rows[i]) begin
         axw(32'h0, {30'h0, rows[i].ctrl}, r);
         st <= rows[i].st;
         repeat (3) @(posedge clock);
         chk(32'(cmd.on), 32'(rows[i].on));
         chk(ua, rows[i].ua);
      end
      for (int c = 0; c < 16; c++) begin
         axw(32'h4, 32'(c), r);
         repeat (4) @(posedge clock);
         chk(32'(cmd.target), 32'(c));
         chk(32'(mv10), c == 15 ? 32'd360 : c == 0 ? 32'd180 : 32'(190 + 10 * c));
      end
      axw(32'h0, 32'h3, r);
      st <= chg_pkg::st_run;
      repeat (3) @(posedge clock);
      chk(ua, 32'h3c);
      uv <= 1'b1;
      repeat (8) @(posedge clock);
      chk(32'(cmd.on), 32'h0);
      axr(32'h0, d, r);
      chk(d, 32'h0);
      axr(32'h8, d, r);
      chk(d, 32'h10);
      axr(32'h4, d, r);
      chk(d, 32'(fuse));
      axw(32'hc, 32'h1, r);
      chk(32'(r), 32'h2);
      axr(32'hc, d, r);
      chk(32'(r), 32'h2);
      test_done();
   end
endmodule : tb_top
